// [ipe_pkg.sv]
// Package for the interrupt pending and priority enable block.
// Assumes a 32-bit AXI4-Lite register bus and 8-bit registers in low bits.
package ipe_pkg;

  localparam int unsigned IPE_AW = 24;
  localparam int unsigned IPE_NSRC = 8;

  // Printed offsets are not all multiples of four: they are register indices
  localparam logic [IPE_AW-1:0] IDX_G0_PEND = 24'hFFE030;
  localparam logic [IPE_AW-1:0] IDX_G0_SET = 24'hFFE031;
  localparam logic [IPE_AW-1:0] IDX_G0_EN_HIGH = 24'hFFE032;
  localparam logic [IPE_AW-1:0] IDX_G0_EN_LOW = 24'hFFE033;
  localparam logic [IPE_AW-1:0] IDX_G2_PEND = 24'hFFE038;
  localparam logic [IPE_AW-1:0] IDX_G2_SET = 24'hFFE039;
  // Own registers: global enable and the presented request
  localparam logic [IPE_AW-1:0] IDX_CTRL = 24'hFFE03C;
  localparam logic [IPE_AW-1:0] IDX_STATUS = 24'hFFE03D;

  // Byte address width: index times four
  localparam int unsigned IPE_BAW = IPE_AW + 2;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_GIE = 1'b0;

  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Group-0 bit positions
  localparam int unsigned G0_TIMER2 = 7;
  localparam int unsigned G0_ADC = 0;
  // Group-2 bit positions
  localparam int unsigned G2_PWM_TIMER = 7;
  localparam int unsigned G2_UART1_RX = 6;
  localparam int unsigned G2_UART1_TX = 5;
  localparam int unsigned G2_PWM_FAULT = 4;

  typedef enum logic [1:0] {
    PRIO_OFF = 2'b00,
    PRIO_LOW = 2'b01,
    PRIO_NOM = 2'b10,
    PRIO_HIGH = 2'b11
  } ipe_prio_t;

  // Request presented to the CPU core
  typedef struct packed {
    logic valid;
    logic [1:0] level;
    logic [2:0] source;
  } ipe_req_t;

  typedef struct packed {
    logic [7:0] en_high;
    logic [7:0] en_low;
    logic [7:0] pending;
  } ipe_g0_t;

endpackage : ipe_pkg

// [ipe_arbiter.sv]
// Picks the highest-priority pending, enabled group-0 request.
// Assumes registered inputs on the same clock; output is registered.
`timescale 1ns/1ps
`default_nettype none
module ipe_arbiter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ipe_pkg::ipe_g0_t g0,
  input wire logic global_enable,
  output ipe_pkg::ipe_req_t req
);
  import ipe_pkg::*;

  ipe_req_t next_req;

  always_comb begin
    logic [1:0] lvl;
    lvl = 2'b00;
    next_req = '0;
    // Higher level wins; within a level the lowest bit index wins
    for (int i = IPE_NSRC - 1; i >= 0; i--) begin
      lvl = {g0.en_high[i], g0.en_low[i]};
      if (g0.pending[i] && lvl != PRIO_OFF && lvl >= next_req.level) begin
        next_req.valid = 1'b1;
        next_req.level = lvl;
        next_req.source = 3'(i);
      end
    end
    if (!global_enable) begin
      next_req = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req <= '0;
    end else begin
      req <= next_req;
    end
  end

endmodule : ipe_arbiter
`default_nettype wire

// [ipe_top.sv]
// Group-0 and group-2 pending registers with set ports, group-0 priority enables.
// Assumes an AXI4-Lite master on aclk and single-cycle request pulses from peripherals
// on the same clock.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ipe_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ipe_pkg::IPE_BAW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ipe_pkg::IPE_BAW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] group0_source_request,
  input wire logic [7:0] group2_source_request,
  output ipe_pkg::ipe_req_t cpu_request
);
  import ipe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0] g0_pend;
  logic [7:0] g0_en_high;
  logic [7:0] g0_en_low;
  logic [7:0] g2_pend;
  logic global_enable;
  logic [7:0] next_g0_pend;
  logic [7:0] next_g0_en_high;
  logic [7:0] next_g0_en_low;
  logic [7:0] next_g2_pend;
  logic next_global_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI write channel state

  logic aw_held;
  logic w_held;
  logic [IPE_AW-1:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [IPE_AW-1:0] next_aw_idx;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;

  // AXI read channel state
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  function automatic logic idx_mapped(input logic [IPE_AW-1:0] idx);
    unique case (idx)
      IDX_G0_PEND, IDX_G0_SET, IDX_G0_EN_HIGH, IDX_G0_EN_LOW,
      IDX_G2_PEND, IDX_G2_SET, IDX_CTRL, IDX_STATUS: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  function automatic logic [IPE_AW-1:0] to_idx(input logic [IPE_BAW-1:0] addr);
    to_idx = addr[IPE_BAW-1:2];
  endfunction : to_idx

  logic do_write;
  logic [7:0] wbyte;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  // Only the low byte lane carries register data
  assign wbyte = w_strb[0] ? w_data[7:0] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Write path: address and data accepted in either order

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_idx = aw_idx;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx = to_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = idx_mapped(aw_idx) && aw_idx != IDX_STATUS ? AXI_OKAY : AXI_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path: one cycle to answer, arready low while rvalid stands

  always_comb begin
    logic [IPE_AW-1:0] ridx;
    ridx = to_idx(s_axi_araddr);
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = AXI_OKAY;
      unique case (ridx)
        IDX_G0_PEND: next_rdata = {24'h000000, g0_pend};
        IDX_G0_EN_HIGH: next_rdata = {24'h000000, g0_en_high};
        IDX_G0_EN_LOW: next_rdata = {24'h000000, g0_en_low};
        IDX_G2_PEND: next_rdata = {24'h000000, g2_pend};
        IDX_G0_SET, IDX_G2_SET: next_rdata = 32'h00000000;
        IDX_CTRL: next_rdata = {31'h00000000, global_enable};
        IDX_STATUS: next_rdata = {26'h0, cpu_request};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pending and enable registers; a source set wins over a same-cycle clear

  always_comb begin
    logic [7:0] g0_clr;
    logic [7:0] g0_set;
    logic [7:0] g2_clr;
    logic [7:0] g2_set;
    g0_clr = (do_write && aw_idx == IDX_G0_PEND) ? wbyte : 8'h00;
    g0_set = (do_write && aw_idx == IDX_G0_SET) ? wbyte : 8'h00;
    g2_clr = (do_write && aw_idx == IDX_G2_PEND) ? wbyte : 8'h00;
    g2_set = (do_write && aw_idx == IDX_G2_SET) ? wbyte : 8'h00;
    // Source bit order follows the group-2 layout directly
    next_g2_pend = (g2_pend & ~g2_clr) | g2_set | group2_source_request;
    next_g0_pend = (g0_pend & ~g0_clr) | g0_set | group0_source_request;
    next_g0_en_high = g0_en_high;
    next_g0_en_low = g0_en_low;
    next_global_enable = global_enable;
    if (do_write && aw_idx == IDX_G0_EN_HIGH && w_strb[0]) begin
      next_g0_en_high = w_data[7:0];
    end
    if (do_write && aw_idx == IDX_G0_EN_LOW && w_strb[0]) begin
      next_g0_en_low = w_data[7:0];
    end
    if (do_write && aw_idx == IDX_CTRL && w_strb[0]) begin
      next_global_enable = w_data[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g0_pend <= RST_BYTE;
      g0_en_high <= RST_BYTE;
      g0_en_low <= RST_BYTE;
      g2_pend <= RST_BYTE;
      global_enable <= RST_GIE;
    end else begin
      g0_pend <= next_g0_pend;
      g0_en_high <= next_g0_en_high;
      g0_en_low <= next_g0_en_low;
      g2_pend <= next_g2_pend;
      global_enable <= next_global_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Priority selection toward the CPU core

  ipe_g0_t g0_view;
  assign g0_view = '{en_high: g0_en_high, en_low: g0_en_low, pending: g0_pend};

  ipe_arbiter u_arbiter (
    .aclk(aclk),
    .aresetn(aresetn),
    .g0(g0_view),
    .global_enable(global_enable),
    .req(cpu_request)
  );

endmodule : ipe_top
`default_nettype wire

// [ipe_cpu_model.sv]
// Core-side model that watches the presented interrupt request.
// Assumes the request is a registered level on aclk.
`timescale 1ns/1ps
`default_nettype none
module ipe_cpu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ipe_pkg::ipe_req_t req,
  output var int unsigned seen
);
  import ipe_pkg::*;
  // Counts offered cycles so the bench can prove silence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen <= 0;
    end else if (req.valid) begin
      seen <= seen + 1;
    end
  end
endmodule : ipe_cpu_model
`default_nettype wire

// [ipe_top_properties.sv]
// Checker for ipe_top bus handshakes and the request output.
// Assumes one clock domain and binding onto ipe_top.
`timescale 1ns/1ps
`default_nettype none
module ipe_top_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ipe_pkg::ipe_req_t cpu_request
);
  import ipe_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("rdata upper bits set");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while answering");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while answering");
  aw_take_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  req_level_a: assert property (cpu_request.valid |-> cpu_request.level != 2'b00)
    else $error("request offered at disabled level");
  cover property (cpu_request.valid);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : ipe_top_properties
////////////////////////////////////////////////////////////////////////////////
bind ipe_top ipe_top_properties i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cpu_request);
`default_nettype wire

// [tb_irq_pending_and_priority_enable.sv]
// Self-checking bench for ipe_top against a behavioural register model.
// Assumes ipe_pkg, ipe_top, the core model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_irq_pending_and_priority_enable;
  import ipe_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [25:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] group0_source_request, group2_source_request, m_h, m_l, m_p0, m_p2, x;
  ipe_req_t cpu_request;
  int unsigned seen, n;
  int failures, total_checks, m_gie;
  logic [23:0] ra[6] = '{IDX_G0_PEND, IDX_G0_SET, IDX_G0_EN_HIGH, IDX_G0_EN_LOW,
    IDX_G2_PEND, IDX_G2_SET};

  ipe_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .group0_source_request, .group2_source_request, .cpu_request);
  ipe_cpu_model i_cpu (.aclk, .aresetn, .req(cpu_request), .seen);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // Readies are sampled at the edge, so valids drop only after a real take
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Status is read-only: a write there is refused
    chk("bresp", {30'h0, a == IDX_STATUS ? AXI_SLVERR : AXI_OKAY}, {30'h0, rr});
  endtask : wr

  task automatic rd(input logic [23:0] a);
    @(posedge aclk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic pulse(input logic [7:0] p0, input logic [7:0] p2);
    @(posedge aclk);
    group0_source_request <= p0;
    group2_source_request <= p2;
    @(posedge aclk);
    group0_source_request <= 8'h00;
    group2_source_request <= 8'h00;
  endtask : pulse

  // Highest level wins, lowest index on a tie
  task automatic chk_req();
    int lv, best, src;
    logic [5:0] e;
    best = 0;
    src = 0;
    for (int i = 7; i >= 0; i--) begin
      lv = 2 * m_h[i] + m_l[i];
      if (m_p0[i] && lv > 0 && lv >= best) begin
        best = lv;
        src = i;
      end
    end
    e = (m_gie != 0 && best > 0) ? {1'b1, best[1:0], src[2:0]} : 6'h00;
    repeat (3) @(posedge aclk);
    chk("cpu_request", {26'h0, e}, {26'h0, e[5] ? cpu_request : cpu_request & 6'h20});
    rd(IDX_STATUS);
    chk("status", {26'h0, e}, rv);
  endtask : chk_req
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {group0_source_request, group2_source_request, m_p0, m_p2} = '0;
    {failures, total_checks, m_gie} = '0;
    void'($urandom(55));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset value", 32'h0, rv);
    end
    rd(24'hFFE020);
    chk("unmapped rresp", {30'h0, AXI_SLVERR}, {30'h0, rr});
    // One-hot sources first to pin each bit's place
    for (int t = 0; t < 16; t++) begin
      x = (t < 8) ? 8'h01 << t : 8'($urandom);
      pulse(8'h00, x);
      m_p2 |= x;
      rd(IDX_G2_PEND);
      chk("g2 after source", {24'h0, m_p2}, rv);
      x = 8'($urandom);
      wr(IDX_G2_PEND, x);
      m_p2 &= ~x;
      rd(IDX_G2_PEND);
      chk("g2 after clear", {24'h0, m_p2}, rv);
      x = 8'($urandom);
      wr(IDX_G2_SET, x);
      m_p2 |= x;
      rd(IDX_G2_PEND);
      chk("g2 after set", {24'h0, m_p2}, rv);
    end
    wr(IDX_CTRL, 8'h01);
    m_gie = 1;
    rd(IDX_CTRL);
    chk("global enable on", 32'h1, rv);
    for (int t = 0; t < 24; t++) begin
      m_h = 8'($urandom);
      m_l = 8'($urandom);
      x = 8'($urandom);
      wr(IDX_G0_EN_HIGH, m_h);
      wr(IDX_G0_EN_LOW, m_l);
      rd(IDX_G0_EN_HIGH);
      chk("enable high", {24'h0, m_h}, rv);
      rd(IDX_G0_EN_LOW);
      chk("enable low", {24'h0, m_l}, rv);
      if (t % 2 == 1) wr(IDX_G0_SET, x);
      else pulse(x, 8'h00);
      m_p0 = x;
      chk_req();
      rd(IDX_G0_PEND);
      chk("g0 pending", {24'h0, m_p0}, rv);
      wr(IDX_G0_PEND, 8'hFF);
      m_p0 = 8'h00;
    end
    // Low lane strobe off: register data must not land
    s_axi_wstrb <= 4'hE;
    wr(IDX_G0_EN_HIGH, ~m_h);
    wr(IDX_STATUS, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rd(IDX_G0_EN_HIGH);
    chk("strobe gate", {24'h0, m_h}, rv);
    wr(IDX_CTRL, 8'h00);
    m_gie = 0;
    rd(IDX_CTRL);
    chk("global enable off", 32'h0, rv);
    wr(IDX_G0_EN_HIGH, 8'hFF);
    m_h = 8'hFF;
    n = seen;
    pulse(8'hFF, 8'h00);
    m_p0 = 8'hFF;
    chk_req();
    rd(IDX_G0_PEND);
    chk("polled pending", 32'hFF, rv);
    chk("core offers", n, seen);
    give_verdict();
  end

  // Whole run needs about eleven hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    give_verdict();
  end
endmodule : tb_irq_pending_and_priority_enable
`default_nettype wire
